// ==== sim/plsr_ctrl_model.sv ====
// Controller model that drives the shift register pins.
`timescale 1ns/1ps
module plsr_ctrl_model (
	input wire logic hclk,
	output plsr_pkg::plsr_pins_s pins
);
	// Idle pins: clear released, shift mode, clock A high, inhibit low.
	initial pins = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00};

	// Drives one pin pattern and keeps it for n clock cycles.
	task automatic hold(input plsr_pkg::plsr_pins_s p, input int n);
		pins <= p;
		repeat (n) @(posedge hclk);
	endtask

	// Loads a parallel word, then lets the parallel lines drift away.
	task automatic load(input logic [7:0] d);
		plsr_pkg::plsr_pins_s p;
		p = pins;
		p.par = d;
		p.shift_load = 1'b0;
		hold(p, 3);
		p.par = ~d;
		p.shift_load = 1'b1;
		hold(p, 2);
	endtask

	// One pulse on clock A; the inhibit only moves while clock A is high.
	task automatic shift(input logic d, input logic inh);
		plsr_pkg::plsr_pins_s p;
		p = pins;
		p.ser = d;
		p.clk_b = inh;
		hold(p, 2);
		p.clk_a = 1'b0;
		hold(p, 3);
		p.clk_a = 1'b1;
		hold(p, 1);
		p.ser = ~d;
		hold(p, 1);
	endtask

	// Clear held together with a pending load of all ones.
	task automatic clear();
		plsr_pkg::plsr_pins_s p;
		p = pins;
		p.clear_n = 1'b0;
		p.shift_load = 1'b0;
		p.par = 8'hFF;
		hold(p, 3);
		p.clear_n = 1'b1;
		p.shift_load = 1'b1;
		hold(p, 2);
	endtask
endmodule

// ==== sim/plsr_top_tb.sv ====
// Self-checking bench for the shift register block.
`timescale 1ns/1ps
`include "plsr_params.svh"
`define CHK(nm, e, g) \
	tests_run++; \
	if ((g) !== (e)) \
	begin \
		$display("wrong value %s exp %h got %h", nm, e, g); \
		n_mismatch++; \
	end
module plsr_top_tb;
	typedef struct packed {
		logic [7:0] par;
		logic ser;
		logic [3:0] n;
		logic [7:0] exp;
	} plsr_row_s;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic ser_out;
	logic [31:0] rd;
	int n_mismatch = 0;
	int tests_run = 0;
	int n_wait = 0;
	plsr_pkg::plsr_pins_s pins;
	plsr_row_s rows [5] = '{
		'{8'hA5, 1'b0, 4'h0, 8'hA5},
		'{8'hA5, 1'b1, 4'h1, 8'h4B},
		'{8'h81, 1'b0, 4'h3, 8'h08},
		'{8'h3C, 1'b1, 4'h8, 8'hFF},
		'{8'hFF, 1'b0, 4'h8, 8'h00}};

	// Free-running bus clock.
	always #2 hclk = ~hclk;

	plsr_ctrl_model model_u (
		.hclk(hclk),
		.pins(pins)
	);

	plsr_top dut_u (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(3'h2),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.pin_clear_n(pins.clear_n),
		.pin_shift_load(pins.shift_load),
		.pin_clk_a(pins.clk_a),
		.pin_clk_b(pins.clk_b),
		.pin_ser(pins.ser),
		.pin_par(pins.par),
		.ser_out(ser_out)
	);

	// Prints the verdict once and ends the run.
	task automatic summarize();
		if (n_mismatch == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// One single word transfer; each phase waits for hready high.
	task automatic ahb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h00000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do
			@(posedge hclk);
		while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		n_wait = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
		begin
			n_wait++;
			@(posedge hclk);
		end
		rd = hrdata;
		`CHK("hresp", 1'b0, hresp)
		repeat (2) @(posedge hclk);
	endtask

	// Reads the status word and checks the stage image and the output.
	task automatic stat(input logic [7:0] e);
		ahb(1'b0, `PLSR_ADDR_STAT, 32'h00000000);
		`CHK("stages", e, rd[7:0])
		`CHK("ser_out", e[7], ser_out)
	endtask

	// Main sequence: reset, table of loads and shifts, then odd cases.
	initial
	begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		`CHK("rst_out", 1'b0, ser_out)
		ahb(1'b0, `PLSR_ADDR_STAT, 32'h00000000);
		`CHK("rst_stat", 32'h00004000, rd)
		foreach (rows[i])
		begin
			model_u.load(rows[i].par);
			repeat (rows[i].n) model_u.shift(rows[i].ser, 1'b0);
			stat(rows[i].exp);
		end
		model_u.load(8'h01);
		model_u.shift(1'b1, 1'b1);
		stat(8'h01);
		model_u.shift(1'b1, 1'b0);
		stat(8'h03);
		model_u.clear();
		stat(8'h00);
		ahb(1'b0, 12'h010, 32'h00000000);
		`CHK("unmapped", 32'h00000000, rd)
		ahb(1'b1, `PLSR_ADDR_CTRL, 32'h00000007);
		ahb(1'b0, `PLSR_ADDR_CTRL, 32'h00000000);
		`CHK("ctrl", 32'h00000007, rd)
		ahb(1'b1, `PLSR_ADDR_CTRL, 32'h00000001);
		for (int i = 0; i < 16; i++)
		begin
			ahb(1'b1, `PLSR_ADDR_FIFO, 32'(i) * 32'h00000011);
			`CHK("fifo_wait", 1, n_wait)
		end
		ahb(1'b0, `PLSR_ADDR_STAT, 32'h00000000);
		`CHK("full", 7'h50, rd[15:9])
		for (int i = 0; i < 16; i++)
		begin
			ahb(1'b1, `PLSR_ADDR_CMD, 32'h00000001);
			stat(8'(i * 8'h11));
		end
		ahb(1'b0, `PLSR_ADDR_STAT, 32'h00000000);
		`CHK("empty", 7'h20, rd[15:9])
		ahb(1'b1, `PLSR_ADDR_CMD, 32'h00000001);
		stat(8'hFF);
		ahb(1'b1, `PLSR_ADDR_CMD, 32'h00000002);
		stat(8'hFE);
		ahb(1'b1, `PLSR_ADDR_CTRL, 32'h00000003);
		ahb(1'b1, `PLSR_ADDR_CMD, 32'h00000002);
		stat(8'hFE);
		ahb(1'b1, `PLSR_ADDR_CMD, 32'h00000004);
		stat(8'h00);
		ahb(1'b1, `PLSR_ADDR_FIFO, 32'h00000080);
		ahb(1'b1, `PLSR_ADDR_CMD, 32'h00000001);
		stat(8'h80);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		`CHK("mid_rst_out", 1'b0, ser_out)
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, `PLSR_ADDR_STAT, 32'h00000000);
		`CHK("mid_rst_stat", 32'h00004000, rd)
		ahb(1'b0, `PLSR_ADDR_CTRL, 32'h00000000);
		`CHK("mid_rst_ctrl", 32'h00000000, rd)
		summarize();
	end

	// Cuts a hung run short; the sequence needs some 530 cycles.
	initial
	begin
		#100us;
		n_mismatch++;
		summarize();
	end
endmodule

// ==== src/plsr_clk.sv ====
// Two-input NOR clock combiner with rising-edge detection.
`timescale 1ns/1ps
module plsr_clk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_a,
	input wire logic clk_b,
	output logic rise
);
	typedef struct packed {
		logic prev;
	} plsr_clk_s;

	plsr_clk_s st;
	plsr_clk_s next_st;
	logic eff;

	// The effective clock is high only while both inputs are low.
	always_comb
	begin
		eff = ~(clk_a | clk_b); // [RULE_06]
		rise = eff & ~st.prev;
		next_st = st;
		next_st.prev = eff;
	end

	// Previous level of the effective clock, low after reset.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st <= '0;
		else
			st <= next_st;
	end

	AST_NOR_EDGE: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_06]
		rise |-> (!clk_a && !clk_b && $past(clk_a || clk_b)))
		else $error("Edge seen without a NOR rising transition.");
endmodule

// ==== src/plsr_fifo.sv ====
// Parameterised FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`include "plsr_params.svh"
module plsr_fifo #(
	parameter int WIDTH = `PLSR_FIFO_WIDTH,
	parameter int DEPTH = `PLSR_FIFO_DEPTH
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] count
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} plsr_fifo_s;

	plsr_fifo_s st;
	plsr_fifo_s next_st;
	logic push;
	logic pop;

	// Full and empty follow the occupancy count exactly.
	always_comb
	begin
		in_ready = (st.cnt != FULL_CNT);
		out_valid = (st.cnt != '0);
		out_data = st.mem[st.rp];
		count = st.cnt;
		push = in_valid & in_ready;
		pop = out_valid & out_ready;
		next_st = st;
		if (push)
		begin
			next_st.mem[st.wp] = in_data;
			next_st.wp = st.wp + 1'b1;
		end
		if (pop)
			next_st.rp = st.rp + 1'b1;
		if (push && !pop)
			next_st.cnt = st.cnt + 1'b1;
		else if (pop && !push)
			next_st.cnt = st.cnt - 1'b1;
	end

	// Pointers and count start empty after reset.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st <= '0;
		else
			st <= next_st;
	end
endmodule

// ==== src/plsr_params.svh ====
// Offsets, field positions and reset values of the shift register block.
`ifndef PLSR_PARAMS_SVH
`define PLSR_PARAMS_SVH
`define PLSR_STAGES 8
`define PLSR_FIFO_WIDTH 8
`define PLSR_FIFO_DEPTH 16
`define PLSR_AW 12
`define PLSR_ADDR_CTRL 12'h000
`define PLSR_ADDR_CMD 12'h004
`define PLSR_ADDR_FIFO 12'h008
`define PLSR_ADDR_STAT 12'h00C
`define PLSR_CTRL_MODE 0
`define PLSR_CTRL_INH 1
`define PLSR_CTRL_SER 2
`define PLSR_CMD_LOAD 0
`define PLSR_CMD_CLK 1
`define PLSR_CMD_CLR 2
`define PLSR_STAT_QH 8
`define PLSR_STAT_CNT 9
`define PLSR_STAT_EMPTY 14
`define PLSR_STAT_FULL 15
`define PLSR_CTRL_RST 3'h0
`endif

// ==== src/plsr_pkg.sv ====
// Types shared by the shift register block.
`include "plsr_params.svh"
package plsr_pkg;
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_WR = 2'b01,
		PH_PUSH = 2'b10
	} plsr_ph_e;

	typedef struct packed {
		logic clear_n;
		logic shift_load;
		logic clk_a;
		logic clk_b;
		logic ser;
		logic [`PLSR_STAGES-1:0] par;
	} plsr_pins_s;

	typedef struct packed {
		logic [`PLSR_STAGES-1:0] stages;
		logic sw_mode;
		logic sw_inh;
		logic sw_ser;
		logic cmd_load;
		logic cmd_clk;
		logic cmd_clr;
		plsr_ph_e ph;
		logic [`PLSR_AW-1:0] daddr;
		logic hready;
		logic hresp;
		logic [31:0] hrdata;
	} plsr_top_s;
endpackage

// ==== src/plsr_top.sv ====
// Eight-stage parallel-load shift register with an AHB-Lite register port.
// Function
// [RULE_01] Eight chained stages; only last stage output; here the status word also reads back every stage.
// [RULE_02] Clear low forces all stages to zero.
// [RULE_03] Select low copies parallel inputs into stages.
// [RULE_04] Shift: serial input enters first stage.
// [RULE_05] Shift: each stage takes preceding stage value.
// [RULE_06] Effective clock is NOR of both clocks.
// [RULE_07] Inhibit input changes only while other high.
// [RULE_08] No active edge leaves all stages unchanged; here select low loads the stages without an edge.
// [RULE_09] Clear wins; one process updates all stages.
`timescale 1ns/1ps
`include "plsr_params.svh"
module plsr_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic pin_clear_n,
	input wire logic pin_shift_load,
	input wire logic pin_clk_a,
	input wire logic pin_clk_b,
	input wire logic pin_ser,
	input wire logic [`PLSR_STAGES-1:0] pin_par,
	output logic ser_out
);
	plsr_pkg::plsr_top_s st;
	plsr_pkg::plsr_top_s next_st;
	plsr_pkg::plsr_pins_s pin;
	plsr_pkg::plsr_pins_s eff;
	logic rise;
	logic acc;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [`PLSR_FIFO_WIDTH-1:0] fifo_out_data;
	logic [$clog2(`PLSR_FIFO_DEPTH+1)-1:0] fifo_count;
	logic [31:0] rd_mux;
	logic [`PLSR_AW-1:0] aaddr;
	// Reset image of the control word; each field is taken from it.
	localparam logic [2:0] CTRL_RST = `PLSR_CTRL_RST;

	// Outputs come straight from the state flip-flops.
	assign hreadyout = st.hready;
	assign hresp = st.hresp;
	assign hrdata = st.hrdata;
	assign ser_out = st.stages[`PLSR_STAGES-1]; // [RULE_01]

	// Gather the external pins into one carrier.
	always_comb
	begin
		pin.clear_n = pin_clear_n;
		pin.shift_load = pin_shift_load;
		pin.clk_a = pin_clk_a;
		pin.clk_b = pin_clk_b;
		pin.ser = pin_ser;
		pin.par = pin_par;
	end

	// In software mode the register port stands in for every pin.
	// A load command only takes effect when the FIFO holds a word.
	always_comb
	begin
		if (st.sw_mode)
		begin
			eff.clear_n = ~st.cmd_clr;
			eff.shift_load = ~(st.cmd_load & fifo_out_valid);
			eff.clk_a = ~st.cmd_clk;
			eff.clk_b = st.sw_inh;
			eff.ser = st.sw_ser;
			eff.par = fifo_out_data;
		end
		else
		begin
			eff = pin;
		end
		// In software mode any load pulse pops the head, even one that a clear beats.
		fifo_out_ready = st.sw_mode & st.cmd_load;
	end

	// Combined clock and its rising edge.
	plsr_clk u_clk (
		.hclk(hclk),
		.hresetn(hresetn),
		.clk_a(eff.clk_a),
		.clk_b(eff.clk_b),
		.rise(rise)
	);

	// Parallel words queued by software; a full queue stalls the bus.
	plsr_fifo #(
		.WIDTH(`PLSR_FIFO_WIDTH),
		.DEPTH(`PLSR_FIFO_DEPTH)
	) u_fifo (
		.hclk(hclk),
		.hresetn(hresetn),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(hwdata[`PLSR_FIFO_WIDTH-1:0]),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data),
		.count(fifo_count)
	);

	// Address phase acceptance and the read-back multiplexer.
	always_comb
	begin
		acc = hsel & htrans[1] & hready;
		aaddr = haddr[`PLSR_AW-1:0];
		fifo_in_valid = (st.ph == plsr_pkg::PH_PUSH);
		rd_mux = 32'h00000000;
		if (aaddr == `PLSR_ADDR_CTRL)
		begin
			rd_mux[`PLSR_CTRL_MODE] = st.sw_mode;
			rd_mux[`PLSR_CTRL_INH] = st.sw_inh;
			rd_mux[`PLSR_CTRL_SER] = st.sw_ser;
		end
		else if (aaddr == `PLSR_ADDR_STAT)
		begin
			rd_mux[`PLSR_STAGES-1:0] = st.stages;
			rd_mux[`PLSR_STAT_QH] = st.stages[`PLSR_STAGES-1];
			rd_mux[`PLSR_STAT_CNT+4:`PLSR_STAT_CNT] = fifo_count;
			rd_mux[`PLSR_STAT_EMPTY] = ~fifo_out_valid;
			rd_mux[`PLSR_STAT_FULL] = ~fifo_in_ready;
		end
	end

	// Next state: the stage chain and the bus slave.
	always_comb
	begin
		next_st = st;
		next_st.cmd_load = 1'b0;
		next_st.cmd_clk = 1'b0;
		next_st.cmd_clr = 1'b0;
		next_st.hresp = 1'b0;
		// Clear first, then load, then shift on an edge, else hold.
		if (!eff.clear_n)
			next_st.stages = '0; // [RULE_02] [RULE_09]
		else if (!eff.shift_load)
			next_st.stages = eff.par; // [RULE_03]
		else if (rise)
		begin
			next_st.stages[0] = eff.ser; // [RULE_04]
			next_st.stages[`PLSR_STAGES-1:1] =
				st.stages[`PLSR_STAGES-2:0]; // [RULE_05]
		end
		// Data phase of an earlier accepted transfer.
		case (st.ph)
			plsr_pkg::PH_WR:
			begin
				if (st.daddr == `PLSR_ADDR_CTRL)
				begin
					next_st.sw_mode = hwdata[`PLSR_CTRL_MODE];
					next_st.sw_inh = hwdata[`PLSR_CTRL_INH];
					next_st.sw_ser = hwdata[`PLSR_CTRL_SER];
				end
				else if (st.daddr == `PLSR_ADDR_CMD)
				begin
					next_st.cmd_load = hwdata[`PLSR_CMD_LOAD];
					next_st.cmd_clk = hwdata[`PLSR_CMD_CLK];
					next_st.cmd_clr = hwdata[`PLSR_CMD_CLR];
				end
				next_st.ph = plsr_pkg::PH_IDLE;
			end
			plsr_pkg::PH_PUSH:
			begin
				if (fifo_in_ready)
				begin
					next_st.hready = 1'b1;
					next_st.ph = plsr_pkg::PH_IDLE;
				end
			end
			default:
			begin
				next_st.ph = plsr_pkg::PH_IDLE;
			end
		endcase
		// A new address phase; FIFO writes take one wait state while the queue has room.
		if (acc)
		begin
			next_st.daddr = aaddr;
			if (hwrite && aaddr == `PLSR_ADDR_FIFO)
			begin
				next_st.ph = plsr_pkg::PH_PUSH;
				next_st.hready = 1'b0;
			end
			else if (hwrite)
				next_st.ph = plsr_pkg::PH_WR;
			else
				next_st.hrdata = rd_mux;
		end
	end

	// All sequential updates happen in this single process.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st <= '0; // [RULE_09]
			st.sw_mode <= CTRL_RST[`PLSR_CTRL_MODE];
			st.sw_inh <= CTRL_RST[`PLSR_CTRL_INH];
			st.sw_ser <= CTRL_RST[`PLSR_CTRL_SER];
			st.hready <= 1'b1;
		end
		else
			st <= next_st;
	end

	// Checks on the stage chain and the bus answer.
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_clear;
		!eff.clear_n;
	endsequence

	sequence s_load;
		eff.clear_n && !eff.shift_load;
	endsequence

	sequence s_shift;
		eff.clear_n && eff.shift_load && rise;
	endsequence

	sequence s_idle;
		eff.clear_n && eff.shift_load && !rise;
	endsequence

	sequence s_fifo_wr;
		acc && hwrite && aaddr == `PLSR_ADDR_FIFO;
	endsequence

	sequence s_ctrl_wr;
		acc && hwrite && aaddr == `PLSR_ADDR_CTRL;
	endsequence

	sequence s_sw_load_empty;
		st.sw_mode && st.cmd_load && !fifo_out_valid;
	endsequence

	AST_CLEAR_EMPTIES: assert property ( // [RULE_02]
		s_clear |=> (st.stages == '0) && !ser_out)
		else $error("Clear did not empty every stage.");

	AST_CLEAR_PRIO: assert property ( // [RULE_09]
		(!eff.clear_n && (!eff.shift_load || rise)) |=> st.stages == '0)
		else $error("Load or shift overrode clear.");

	AST_LOAD_COPIES: assert property ( // [RULE_03]
		s_load |=> st.stages == $past(eff.par))
		else $error("Parallel load did not copy the inputs.");

	AST_LOAD_OUT: assert property ( // [RULE_01]
		s_load |=> ser_out == $past(eff.par[`PLSR_STAGES-1]))
		else $error("Output does not show the last loaded stage.");

	AST_SHIFT_FIRST: assert property ( // [RULE_04]
		s_shift |=> st.stages[0] == $past(eff.ser))
		else $error("Serial input did not enter the first stage.");

	AST_SHIFT_CHAIN: assert property ( // [RULE_05]
		s_shift |=> st.stages[`PLSR_STAGES-1:1] ==
			$past(st.stages[`PLSR_STAGES-2:0]))
		else $error("Stages did not take the preceding value.");

	AST_HOLD: assert property ( // [RULE_08]
		s_idle |=> $stable(st.stages))
		else $error("Stages changed without an active edge.");

	AST_INHIBIT: assert property ( // [RULE_08]
		(eff.clear_n && eff.shift_load && eff.clk_b) |=> $stable(st.stages))
		else $error("Inhibit high did not block the shift.");

	AST_FIFO_WAIT: assert property (
		s_fifo_wr |=> !hreadyout ##[1:64] hreadyout)
		else $error("FIFO write wait state missing or endless.");

	AST_RESP_OKAY: assert property (
		hresp == 1'b0)
		else $error("Slave answered other than OKAY.");

	AST_SHIFT_OUT: assert property ( // [RULE_01]
		s_shift |=> ser_out == $past(st.stages[`PLSR_STAGES-2]))
		else $error("Output did not take the stage before it.");

	AST_NO_EDGE_HIGH: assert property ( // [RULE_06]
		(eff.clk_a || eff.clk_b) |-> !rise)
		else $error("Edge reported while a clock input is high.");

	AST_SW_INHIBIT: assert property ( // [RULE_08]
		(st.sw_mode && st.sw_inh) |-> !rise)
		else $error("Software inhibit did not block the clock.");

	AST_EMPTY_LOAD: assert property ( // [RULE_03]
		(s_sw_load_empty ##0 (eff.clear_n && !rise)) |=>
			$stable(st.stages))
		else $error("Load from an empty queue changed the stages.");

	// Checks on the register side and the queue behind it.
	AST_CTRL_WRITE: assert property ( // [RULE_08]
		(s_ctrl_wr ##1 1'b1) |=>
			(st.sw_mode == $past(hwdata[`PLSR_CTRL_MODE])) &&
			(st.sw_inh == $past(hwdata[`PLSR_CTRL_INH])) &&
			(st.sw_ser == $past(hwdata[`PLSR_CTRL_SER])))
		else $error("Control write did not land in the data phase.");

	AST_ZERO_WAIT: assert property (
		(acc && !(hwrite && aaddr == `PLSR_ADDR_FIFO)) |=> hreadyout)
		else $error("Register access inserted a wait state.");

	AST_RD_HOLD: assert property (
		!(acc && !hwrite) |=> $stable(hrdata))
		else $error("Read data changed without a new read.");

	AST_FIFO_PUSH: assert property ( // [RULE_03]
		(fifo_in_valid && fifo_in_ready &&
			!(fifo_out_valid && fifo_out_ready)) |=>
			fifo_count == $past(fifo_count) + 1'b1)
		else $error("Queue count did not rise on a push.");

	AST_FIFO_POP: assert property ( // [RULE_03]
		(fifo_out_valid && fifo_out_ready &&
			!(fifo_in_valid && fifo_in_ready)) |=>
			fifo_count == $past(fifo_count) - 1'b1)
		else $error("Queue count did not fall on a pop.");
endmodule
